// ==== core/network_receive_buffer_unload.sv ====
// Receive side of a network link adapter: deserialiser, frame status,
// receive memory with free/used buffer lists, and the port unload path.
// Assumes an APB master on pclk and a decoded serial bit stream from the
// wire (asynchronous) or from the local encoder loopback (synchronous).
`timescale 1ns/1ps
`include "rx_unload_params.svh"

module network_receive_buffer_unload (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        line_carrier,
	input  wire logic        line_data,
	input  wire logic        line_strobe,
	input  wire logic        loop_carrier,
	input  wire logic        loop_data,
	input  wire logic        loop_strobe,
	input  wire logic [15:0] reflect_count,
	output logic             rx_attention,
	output logic             loopback_en,
	output logic             heartbeat_check_en,
	output logic             collision_test_en,
	output logic             crc_check_off
);

	logic [1:0]  car_s;
	logic [1:0]  dat_s;
	logic [1:0]  stb_s;
	logic        stb_d;
	logic        in_car;
	logic        in_bit;
	logic        in_stb;

	logic        ctl_rx_en;
	logic        ctl_promisc;
	logic        ctl_bad_par;
	logic [1:0]  ctl_org;
	logic [47:0] station;

	logic        setup;
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;

	logic [6:0]  free_mem [0:7];
	logic [2:0]  free_wr;
	logic [2:0]  free_rd;
	logic [3:0]  free_cnt;
	logic [5:0]  used_mem [0:7];
	logic [2:0]  used_wr;
	logic [2:0]  used_rd;
	logic [3:0]  used_cnt;
	logic [7:0]  stat_mem [0:7];
	logic [2:0]  stat_wr;
	logic [2:0]  stat_rd;
	logic [3:0]  stat_cnt;

	logic [10:0] rx_mem [0:16383];
	logic [13:0] rd_addr;
	logic [13:0] rd_next;

	rx_unload_pkg::rx_state_t state;
	logic [7:0]  sr;
	logic [2:0]  bitc;
	logic        prev_bit;
	logic [31:0] crc;
	logic [31:0] crc_byte;
	logic [10:0] byte_cnt;
	logic [9:0]  off;
	logic [5:0]  buf_ptr;
	logic        have_buf;
	logic        storing;
	logic        dest_match;
	logic        group_dest;
	logic        halted;
	logic        f_align;
	logic        f_ovf;
	logic        f_empty;
	logic        f_fpar;
	logic [2:0]  bufs;
	logic [2:0]  bufs_total;

	logic        byte_done;
	logic [7:0]  next_byte;
	logic [31:0] next_crc;
	logic        want;
	logic        can_get;
	logic        free_pop;
	logic        head_bad;
	logic [6:0]  head;
	logic [5:0]  cur_ptr;
	logic        rx_we;
	logic [10:0] rx_word;
	logic [13:0] rx_addr;
	logic        buf_end;
	logic        used_push;
	logic        stat_push;
	logic [7:0]  status_word;
	logic        accept;
	logic        port_we;

	// Wire inputs are asynchronous; stage two is looked at, plus a delayed copy of the strobe for its edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			car_s <= 2'h0;
			dat_s <= 2'h0;
			stb_s <= 2'h0;
			stb_d <= 1'b0;
		end else begin
			car_s <= {car_s[0], line_carrier};
			dat_s <= {dat_s[0], line_data};
			stb_s <= {stb_s[0], line_strobe};
			stb_d <= stb_s[1];
		end
	end

	// Loopback takes the encoder output straight back into the deserialiser
	assign in_car = loopback_en ? loop_carrier : car_s[1];
	assign in_bit = loopback_en ? loop_data : dat_s[1];
	assign in_stb = loopback_en ? loop_strobe : (stb_s[1] & ~stb_d);

	assign setup  = psel & ~penable;
	assign acc    = psel & penable & pready;
	assign wr_acc = acc & pwrite;
	assign rd_acc = acc & ~pwrite;

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_rx_en          <= 1'b0;
			loopback_en        <= 1'b0;
			crc_check_off      <= 1'b0;
			ctl_promisc        <= 1'b0;
			ctl_bad_par        <= 1'b0;
			heartbeat_check_en <= 1'b0;
			collision_test_en  <= 1'b0;
			ctl_org            <= 2'h0;
		end else if (wr_acc && paddr == `OFF_CTRL) begin
			ctl_rx_en          <= pwdata[`CTRL_RX_EN];
			loopback_en        <= pwdata[`CTRL_LOOP];
			crc_check_off      <= pwdata[`CTRL_CRC_OFF];
			ctl_promisc        <= pwdata[`CTRL_PROMISC];
			ctl_bad_par        <= pwdata[`CTRL_BAD_PAR];
			heartbeat_check_en <= pwdata[`CTRL_HEARTBEAT];
			collision_test_en  <= pwdata[`CTRL_COLL_TEST]
				& pwdata[`CTRL_LOOP];
			ctl_org            <= pwdata[`CTRL_ORG_LO +: 2];
		end
	end

	// Station address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station <= 48'h0;
		end else if (wr_acc && paddr == `OFF_STATION_LO) begin
			station[31:0] <= pwdata;
		end else if (wr_acc && paddr == `OFF_STATION_HI) begin
			station[47:32] <= pwdata[15:0];
		end
	end

	// APB answer: ready one cycle after setup, so every access takes two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			unique case (paddr)
				`OFF_CTRL: prdata <= {23'h0, ctl_org, collision_test_en,
					heartbeat_check_en, ctl_bad_par, ctl_promisc,
					crc_check_off, loopback_en, ctl_rx_en};
				`OFF_CMD: prdata <= {18'h0, halted, free_cnt, used_cnt,
					stat_cnt, rx_attention};
				`OFF_RX_STATUS: prdata <= {23'h0, stat_cnt != 4'h0,
					stat_mem[stat_rd]};
				`OFF_FREE_LIST: prdata <= {28'h0, free_cnt};
				`OFF_USED_LIST: prdata <= {23'h0, used_cnt != 4'h0, 2'h0,
					used_mem[used_rd]};
				`OFF_RD_ADDR: prdata <= {18'h0, rd_addr};
				// Bit 11 marks the final byte; bit 10 is the stored marker
				`OFF_RX_DATA: prdata <= {20'h0,
					rx_mem[rd_next][`WORD_EOF_BIT],
					rx_mem[rd_addr]};
				`OFF_STATION_LO: prdata <= station[31:0];
				`OFF_STATION_HI: prdata <= {16'h0, station[47:32]};
				`OFF_REFLECT: prdata <= {16'h0, reflect_count};
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Read address: loaded by the port, bumped after every data access
	assign rd_next = rd_addr + 14'h1;
	assign port_we = wr_acc && paddr == `OFF_RX_DATA
		&& state == rx_unload_pkg::RX_IDLE && !rx_we;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_addr <= 14'h0;
		end else if (wr_acc && paddr == `OFF_RD_ADDR) begin
			rd_addr <= pwdata[13:0];
		end else if (acc && paddr == `OFF_RX_DATA) begin
			rd_addr <= rd_next;
		end
	end

	// Receiver owns the write port; direct port writes only while idle
	always_ff @(posedge pclk) begin
		if (rx_we) begin
			rx_mem[rx_addr] <= rx_word;
		end else if (port_we) begin
			rx_mem[rd_addr] <= {pwdata[`WORD_EOF_BIT], 1'b0,
				~^pwdata[7:0] ^ ctl_bad_par, pwdata[7:0]};
		end
	end

	// Free list: port pushes pointers with parity, receiver pops
	assign head     = free_mem[free_rd];
	assign head_bad = ~^head;
	assign can_get  = have_buf | (free_cnt != 4'h0 && !head_bad);
	assign free_pop = want & ~have_buf & free_cnt != 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			free_wr  <= 3'h0;
			free_rd  <= 3'h0;
			free_cnt <= 4'h0;
		end else begin
			if (wr_acc && paddr == `OFF_FREE_LIST && free_cnt != `FIFO_DEPTH) begin
				free_mem[free_wr] <= {~^pwdata[5:0] ^ pwdata[`FREE_PAR_BIT],
					pwdata[5:0]};
				free_wr <= free_wr + 3'h1;
			end
			if (free_pop) begin
				free_rd <= free_rd + 3'h1;
			end
			free_cnt <= free_cnt
				+ {3'h0, wr_acc && paddr == `OFF_FREE_LIST
				&& free_cnt != `FIFO_DEPTH}
				- {3'h0, free_pop};
		end
	end

	// Used list and status store: receiver pushes, port pops on read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			used_wr  <= 3'h0;
			used_rd  <= 3'h0;
			used_cnt <= 4'h0;
			stat_wr  <= 3'h0;
			stat_rd  <= 3'h0;
			stat_cnt <= 4'h0;
		end else begin
			if (used_push && used_cnt != `FIFO_DEPTH) begin
				used_mem[used_wr] <= cur_ptr;
				used_wr <= used_wr + 3'h1;
			end
			if (rd_acc && paddr == `OFF_USED_LIST && used_cnt != 4'h0) begin
				used_rd <= used_rd + 3'h1;
			end
			used_cnt <= used_cnt
				+ {3'h0, used_push && used_cnt != `FIFO_DEPTH}
				- {3'h0, rd_acc && paddr == `OFF_USED_LIST
				&& used_cnt != 4'h0};
			if (stat_push && stat_cnt != `FIFO_DEPTH) begin
				stat_mem[stat_wr] <= status_word;
				stat_wr <= stat_wr + 3'h1;
			end
			if (rd_acc && paddr == `OFF_RX_STATUS && stat_cnt != 4'h0) begin
				stat_rd <= stat_rd + 3'h1;
			end
			stat_cnt <= stat_cnt
				+ {3'h0, stat_push && stat_cnt != `FIFO_DEPTH}
				- {3'h0, rd_acc && paddr == `OFF_RX_STATUS
				&& stat_cnt != 4'h0};
		end
	end

	// Write datapath
	assign byte_done = state == rx_unload_pkg::RX_DATA && in_stb
		&& bitc == 3'h7;
	assign next_byte = {in_bit, sr[7:1]};
	assign next_crc  = (crc >> 1)
		^ ((crc[0] ^ in_bit) ? `CRC_POLY : 32'h0);
	assign want = (byte_done && storing && byte_cnt != `MAX_FRAME_BYTES)
		|| (state == rx_unload_pkg::RX_FINISH && storing);
	assign cur_ptr = have_buf ? buf_ptr : head[5:0];
	assign rx_we   = want & can_get;
	assign rx_word = (state == rx_unload_pkg::RX_FINISH)
		? {1'b1, 1'b0, ~ctl_bad_par, 8'h00}
		: {2'b00, ~^next_byte ^ ctl_bad_par, next_byte};

	always_comb begin
		unique case (ctl_org)
			rx_unload_pkg::ORG_32X512: begin
				rx_addr = {cur_ptr[4:0], off[8:0]};
				buf_end = off[8:0] == 9'h1FF;
			end
			rx_unload_pkg::ORG_16X1024: begin
				rx_addr = {cur_ptr[3:0], off};
				buf_end = off == 10'h3FF;
			end
			default: begin
				rx_addr = {cur_ptr, off[7:0]};
				buf_end = off[7:0] == 8'hFF;
			end
		endcase
	end

	assign used_push = (rx_we && buf_end)
		|| (state == rx_unload_pkg::RX_STATUS && have_buf);
	assign stat_push = state == rx_unload_pkg::RX_STATUS;
	assign accept = ctl_promisc || group_dest
		|| (dest_match && next_byte == station[47:40]);
	// The closing buffer is pushed in the status cycle itself, so count it
	assign bufs_total  = bufs + {2'h0, used_push && bufs != 3'h7};
	assign status_word = {f_fpar, bufs_total, f_empty,
		~crc_check_off && crc_byte != `CRC_RESIDUE,
		f_ovf, f_align};

	// Receive state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= rx_unload_pkg::RX_IDLE;
		end else begin
			unique case (state)
				rx_unload_pkg::RX_IDLE:
					if (in_car && ctl_rx_en && !halted)
						state <= rx_unload_pkg::RX_PREAMBLE;
				rx_unload_pkg::RX_PREAMBLE:
					if (!in_car)
						state <= rx_unload_pkg::RX_IDLE;
					else if (in_stb && prev_bit && in_bit)
						state <= rx_unload_pkg::RX_DATA;
				rx_unload_pkg::RX_DATA:
					if (!in_car)
						state <= rx_unload_pkg::RX_FINISH;
					else if (byte_done && byte_cnt == 11'd5 && !accept)
						state <= rx_unload_pkg::RX_DISCARD;
				rx_unload_pkg::RX_DISCARD:
					if (!in_car)
						state <= rx_unload_pkg::RX_IDLE;
				rx_unload_pkg::RX_FINISH:
					state <= rx_unload_pkg::RX_STATUS;
				rx_unload_pkg::RX_STATUS:
					state <= rx_unload_pkg::RX_IDLE;
				default:
					state <= rx_unload_pkg::RX_IDLE;
			endcase
		end
	end

	// Shifter, CRC and counters; CRC is sampled at each byte boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr       <= 8'h0;
			bitc     <= 3'h0;
			prev_bit <= 1'b0;
			crc      <= `CRC_INIT;
			crc_byte <= `CRC_INIT;
			byte_cnt <= 11'h0;
		end else if (state == rx_unload_pkg::RX_PREAMBLE) begin
			bitc     <= 3'h0;
			crc      <= `CRC_INIT;
			crc_byte <= `CRC_INIT;
			byte_cnt <= 11'h0;
			if (in_stb)
				prev_bit <= in_bit;
		end else if (state == rx_unload_pkg::RX_DATA && in_stb) begin
			sr   <= next_byte;
			bitc <= bitc + 3'h1;
			crc  <= next_crc;
			if (bitc == 3'h7) begin
				crc_byte <= next_crc;
				if (byte_cnt != `MAX_FRAME_BYTES)
					byte_cnt <= byte_cnt + 11'h1;
			end
		end else if (state == rx_unload_pkg::RX_IDLE) begin
			prev_bit <= 1'b0;
		end
	end

	// Destination filter over the first six bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dest_match <= 1'b0;
			group_dest <= 1'b0;
		end else if (state == rx_unload_pkg::RX_PREAMBLE) begin
			dest_match <= 1'b1;
			group_dest <= 1'b0;
		end else if (byte_done && byte_cnt < `DEST_BYTES) begin
			if (next_byte != station[{byte_cnt[2:0], 3'b000} +: 8])
				dest_match <= 1'b0;
			if (byte_cnt == 11'h0)
				group_dest <= next_byte[0];
		end
	end

	// Buffer pointer, write counter and buffer count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_ptr  <= 6'h0;
			have_buf <= 1'b0;
			off      <= 10'h0;
			bufs     <= 3'h0;
		end else begin
			if (rx_we) begin
				buf_ptr  <= cur_ptr;
				have_buf <= !buf_end;
				off      <= buf_end ? 10'h0 : off + 10'h1;
			end else if (free_pop) begin
				have_buf <= 1'b0;
			end
			if (state == rx_unload_pkg::RX_PREAMBLE)
				bufs <= 3'h0;
			else if (used_push && bufs != 3'h7)
				bufs <= bufs + 3'h1;
			// Rejected frame: rewind and keep the buffer for the next one
			if (byte_done && byte_cnt == 11'd5 && !accept)
				off <= 10'h0;
			if (state == rx_unload_pkg::RX_STATUS) begin
				have_buf <= 1'b0;
				off      <= 10'h0;
			end
		end
	end

	// Per-frame error flags, all cleared at the start of each frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			storing <= 1'b0;
			f_align <= 1'b0;
			f_ovf   <= 1'b0;
			f_empty <= 1'b0;
			f_fpar  <= 1'b0;
		end else if (state == rx_unload_pkg::RX_PREAMBLE) begin
			storing <= 1'b1;
			f_align <= 1'b0;
			f_ovf   <= 1'b0;
			f_empty <= 1'b0;
			f_fpar  <= 1'b0;
		end else begin
			if (state == rx_unload_pkg::RX_DATA && !in_car)
				f_align <= bitc != 3'h0;
			if (byte_done && byte_cnt == `MAX_FRAME_BYTES) begin
				f_ovf   <= 1'b1;
				storing <= 1'b0;
			end
			if (want && !have_buf && free_cnt == 4'h0) begin
				f_empty <= 1'b1;
				storing <= 1'b0;
			end
			if (free_pop && head_bad) begin
				f_fpar  <= 1'b1;
				storing <= 1'b0;
			end
			if (byte_done && byte_cnt == 11'd5 && !accept)
				storing <= 1'b0;
		end
	end

	// Halt and attention: a set in the same cycle as a clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halted       <= 1'b0;
			rx_attention <= 1'b0;
		end else begin
			if (free_pop && head_bad)
				halted <= 1'b1;
			else if (wr_acc && paddr == `OFF_CMD && pwdata[`CMD_CLR_HALT])
				halted <= 1'b0;
			if (state == rx_unload_pkg::RX_STATUS)
				rx_attention <= 1'b1;
			else if (wr_acc && paddr == `OFF_CMD && pwdata[`CMD_CLR_ATTN])
				rx_attention <= 1'b0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_frame_end;
		state == rx_unload_pkg::RX_DATA && !in_car
			##1 state == rx_unload_pkg::RX_FINISH;
	endsequence

	a_frame_to_attn: assert property (
		s_frame_end |-> ##2 rx_attention && stat_cnt != 4'h0
			|| stat_cnt == `FIFO_DEPTH)
		else $error("attention not raised two cycles after finish");
	a_attn_held: assert property (
		rx_attention && !(wr_acc && paddr == `OFF_CMD) |=> rx_attention)
		else $error("attention dropped without a clear");
	a_eof_bit_ten: assert property (
		rx_we && state == rx_unload_pkg::RX_FINISH |-> rx_word[10]
			&& rx_word[7:0] == 8'h00)
		else $error("end marker word malformed");
	a_rd_increment: assert property (
		acc && paddr == `OFF_RX_DATA |=> rd_addr == $past(rd_addr) + 14'h1)
		else $error("read address did not advance");
	a_par_halts: assert property (
		free_pop && head_bad |=> halted && !storing
			##1 state != rx_unload_pkg::RX_PREAMBLE)
		else $error("free list parity error did not halt");
	a_inv_parity: assert property (
		rx_we && state == rx_unload_pkg::RX_DATA |-> rx_word[8]
			== (~^rx_word[7:0] ^ ctl_bad_par))
		else $error("stored parity wrong");
	a_overflow_flag: assert property (
		byte_done && byte_cnt == `MAX_FRAME_BYTES |=> f_ovf && !rx_we)
		else $error("overflow not flagged");
	a_low_addr: assert property (
		rx_we |-> rx_addr[7:0] == off[7:0])
		else $error("low address bits not from write counter");
	a_coll_loop_only: assert property (
		collision_test_en |-> loopback_en)
		else $error("collision test outside loopback");
	a_empty_flag: assert property (
		want && !have_buf && free_cnt == 4'h0 |=> f_empty && !storing)
		else $error("empty free list not flagged");

endmodule // network_receive_buffer_unload

// ==== core/rx_unload_params.svh ====
// Constants for the receive buffer unload block: register offsets,
// field positions, reset values and frame limits.
// Assumes byte addresses on a 32-bit APB slave, one register per word.
`ifndef RX_UNLOAD_PARAMS_SVH
`define RX_UNLOAD_PARAMS_SVH

`define OFF_CTRL        8'h00
`define OFF_CMD         8'h04
`define OFF_RX_STATUS   8'h08
`define OFF_FREE_LIST   8'h0C
`define OFF_USED_LIST   8'h10
`define OFF_RD_ADDR     8'h14
`define OFF_RX_DATA     8'h18
`define OFF_STATION_LO  8'h1C
`define OFF_STATION_HI  8'h20
`define OFF_REFLECT     8'h24

`define CTRL_RX_EN      0
`define CTRL_LOOP       1
`define CTRL_CRC_OFF    2
`define CTRL_PROMISC    3
`define CTRL_BAD_PAR    4
`define CTRL_HEARTBEAT  5
`define CTRL_COLL_TEST  6
`define CTRL_ORG_LO     7
`define CTRL_RESET      32'h0000_0000

`define CMD_CLR_ATTN    0
`define CMD_CLR_HALT    1

`define FREE_PAR_BIT    8
`define WORD_EOF_BIT    10
`define WORD_PAR_BIT    8

`define ST_BIT_ALIGN    0
`define ST_OVERFLOW     1
`define ST_CRC_ERR      2
`define ST_FREE_EMPTY   3
`define ST_BUFS_LO      4
`define ST_FREE_PAR     7

`define MAX_FRAME_BYTES 11'd1536
`define DEST_BYTES      11'd6
`define CRC_INIT        32'hFFFF_FFFF
`define CRC_POLY        32'hEDB8_8320
`define CRC_RESIDUE     32'hDEBB_20E3
`define FIFO_DEPTH      4'h8

`endif

// ==== core/rx_unload_pkg.sv ====
// Types shared by the receive buffer unload block.
// Assumes the constants header is included where numbers are needed.
package rx_unload_pkg;

	typedef enum logic [5:0] {
		RX_IDLE     = 6'b000001,
		RX_PREAMBLE = 6'b000010,
		RX_DATA     = 6'b000100,
		RX_DISCARD  = 6'b001000,
		RX_FINISH   = 6'b010000,
		RX_STATUS   = 6'b100000
	} rx_state_t;

	typedef enum logic [1:0] {
		ORG_64X256  = 2'b00,
		ORG_32X512  = 2'b01,
		ORG_16X1024 = 2'b10
	} mem_org_t;

endpackage

// ==== tb/frame_source.sv ====
// Loopback bit source standing in for the wire side of the receiver.
// Assumes the caller sits on a rising edge of pclk.
`timescale 1ns/1ps
module frame_source (
	input  wire logic pclk,
	output logic      carrier,
	output logic      data,
	output logic      strobe
);
	logic busy = 1'b0;
	logic bitv = 1'b0;
	logic idle = 1'b0;
	initial begin
		carrier = 1'b0;
		strobe = 1'b0;
	end
	// Idle line toggles so a stale bit never passes for data
	always @(posedge pclk) idle <= ~idle;
	assign data = busy ? bitv : idle;
	task automatic put(input logic b);
		bitv <= b;
		strobe <= 1'b1;
		@(posedge pclk) strobe <= 1'b0;
		@(posedge pclk);
	endtask
	// Preamble ends in two ones; bytes go out low bit first
	task automatic send(input logic [7:0] q[$], input int extra);
		busy <= 1'b1;
		carrier <= 1'b1;
		for (int i = 0; i < 64; i++) put(i >= 62 || !i[0]);
		foreach (q[k]) for (int b = 0; b < 8; b++) put(q[k][b]);
		for (int e = 0; e < extra; e++) put(1'b1);
		carrier <= 1'b0;
		busy <= 1'b0;
	endtask
endmodule // frame_source

// ==== tb/tb.sv ====
// Self-checking bench for the receive buffer unload block.
// Assumes the loopback source model and a wait-free APB slave.
`timescale 1ns/1ps
`include "rx_unload_params.svh"
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        lc, ld, ls, attn, loop_en, hb_en, coll_en, crc_off;
	logic [15:0] reflect_count;
	logic [7:0]  fr[$];
	int          error_cnt = 0;
	int          comparisons = 0;
	frame_source u_src (.pclk(pclk), .carrier(lc), .data(ld), .strobe(ls));
	network_receive_buffer_unload u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_carrier(1'b0), .line_data(1'b0),
		.line_strobe(1'b0), .loop_carrier(lc), .loop_data(ld),
		.loop_strobe(ls), .reflect_count(reflect_count),
		.rx_attention(attn), .loopback_en(loop_en),
		.heartbeat_check_en(hb_en), .collision_test_en(coll_en),
		.crc_check_off(crc_off));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic conclude();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("BAD %0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// Request stands until pready is seen high at a rising edge, or until 50 more edges pass
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50) error_cnt++;
		r = pslverr ? 32'hDEAD : prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_attn();
		int n;
		n = 0;
		while (attn !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(attn), 32'h1);
	endtask
	// Frame of n bytes stepping by seven from one, followed by its check sequence
	task automatic mk(input int n);
		logic [31:0] c;
		c = 32'hFFFF_FFFF;
		fr = {};
		for (int i = 0; i < n; i++) fr.push_back(8'(i * 7 + 1));
		foreach (fr[i]) for (int b = 0; b < 8; b++)
			c = (c >> 1) ^ ((c[0] ^ fr[i][b]) ? 32'hEDB8_8320 : 32'h0);
		for (int k = 0; k < 4; k++) fr.push_back(~c[k * 8 +: 8]);
	endtask
	task automatic good(input logic [31:0] ctrl, input logic wp,
		input logic [13:0] base);
		apb(1, `OFF_CTRL, ctrl | (32'(wp) << 4));
		mk(12);
		u_src.send(fr, 0);
		wait_attn();
		apb(0, `OFF_RX_STATUS, 0);
		chk(r & 32'h1FF, 32'h110);
		apb(0, `OFF_USED_LIST, 0);
		chk(r & 32'h13F, 32'h105);
		apb(1, `OFF_RD_ADDR, 32'(base));
		foreach (fr[i]) begin
			apb(0, `OFF_RX_DATA, 0);
			chk(r & 32'hDFF, {20'h0, i == fr.size() - 1, 2'b00,
				~^fr[i] ^ wp, fr[i]});
		end
		chk(32'(attn), 32'h1);
		apb(1, `OFF_FREE_LIST, 32'h5);
		apb(1, `OFF_CMD, 32'h1);
		@(posedge pclk);
		chk(32'(attn), 32'h0);
	endtask
	task automatic bad(input int n, input int extra, input logic flip,
		input logic [31:0] mask, input logic [31:0] exp);
		mk(n);
		fr[n] = fr[n] ^ 8'(flip);
		u_src.send(fr, extra);
		wait_attn();
		apb(0, `OFF_RX_STATUS, 0);
		chk(r & mask, exp);
		apb(0, `OFF_USED_LIST, 0);
		if (r[8] === 1'b1) apb(1, `OFF_FREE_LIST, r & 32'h3F);
		apb(1, `OFF_CMD, 32'h1);
	endtask
	initial begin
		repeat (80000) @(posedge pclk);
		error_cnt++;
		conclude();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		reflect_count = 16'hA5C3;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `OFF_CTRL, 0);
		chk(r, `CTRL_RESET);
		apb(0, 8'h28, 0);
		chk(r, 32'hDEAD);
		apb(0, `OFF_REFLECT, 0);
		chk(r, 32'hA5C3);
		apb(1, `OFF_CTRL, 32'h66);
		@(posedge pclk);
		chk(32'({loop_en, crc_off, hb_en, coll_en}), 32'hF);
		apb(1, `OFF_CTRL, 32'h40);
		@(posedge pclk);
		chk(32'({loop_en, crc_off, hb_en, coll_en}), 32'h0);
		apb(1, `OFF_RD_ADDR, 32'h300);
		apb(1, `OFF_RX_DATA, 32'h5A5);
		apb(1, `OFF_RD_ADDR, 32'h300);
		apb(0, `OFF_RX_DATA, 0);
		chk(r & 32'h5FF, 32'h5A5);
		apb(1, `OFF_CTRL, 32'hB);
		bad(12, 0, 0, 32'h108, 32'h108);
		apb(1, `OFF_FREE_LIST, 32'h105);
		mk(12);
		u_src.send(fr, 0);
		repeat (20) @(posedge pclk);
		apb(0, `OFF_RX_STATUS, 0);
		chk(r & 32'h180, 32'h180);
		apb(1, `OFF_CMD, 32'h1);
		apb(1, `OFF_FREE_LIST, 32'h5);
		u_src.send(fr, 0);
		apb(0, `OFF_CMD, 0);
		chk(r & 32'h2001, 32'h2000);
		apb(1, `OFF_CMD, 32'h2);
		apb(0, `OFF_CMD, 0);
		chk(r & 32'h2000, 32'h0);
		apb(0, `OFF_USED_LIST, 0);
		good(32'hB, 0, 14'h500);
		apb(1, `OFF_STATION_LO, 32'h160F_0801);
		apb(1, `OFF_STATION_HI, 32'h241D);
		good(32'h83, 1, 14'hA00);
		// Unicast frame for another station: dropped unless promiscuous
		apb(1, `OFF_CTRL, 32'h3);
		mk(12);
		fr[0] = 8'h02;
		u_src.send(fr, 0);
		repeat (8) @(posedge pclk);
		apb(0, `OFF_CMD, 0);
		chk(r & 32'h1F, 32'h0);
		apb(1, `OFF_CTRL, 32'hB);
		u_src.send(fr, 0);
		wait_attn();
		apb(0, `OFF_RX_STATUS, 0);
		chk(r & 32'h17B, 32'h110);
		apb(0, `OFF_USED_LIST, 0);
		apb(1, `OFF_FREE_LIST, r & 32'h3F);
		apb(1, `OFF_CMD, 32'h1);
		apb(1, `OFF_CTRL, 32'h10B);
		bad(12, 3, 0, 32'h18F, 32'h101);
		bad(12, 0, 1, 32'h18F, 32'h104);
		apb(1, `OFF_CTRL, 32'hF);
		bad(12, 0, 1, 32'h18F, 32'h100);
		apb(1, `OFF_CTRL, 32'hB);
		for (int p = 1; p < 8; p++) apb(1, `OFF_FREE_LIST, 32'(p + 16));
		bad(1540, 0, 0, 32'h102, 32'h102);
		apb(0, `OFF_USED_LIST, 0);
		apb(1, `OFF_RD_ADDR, {18'h0, r[5:0], 8'h00});
		apb(0, `OFF_RX_DATA, 0);
		chk(r & 32'h1FF, {23'h0, ~^fr[256], fr[256]});
		conclude();
	end
endmodule // tb
